// >>> rtl/hwc_pkg.sv
// constants for the host hardware configuration register block
package hwc_pkg;
	// command codes on the processor port
	localparam logic [7:0] HWC_RD_CODE = 8'h20;
	localparam logic [7:0] HWC_WR_CODE = 8'ha0;
	// field positions
	localparam int unsigned HWC_IRQ_EN_BIT = 0;
	localparam int unsigned HWC_IRQ_TRIG_BIT = 1;
	localparam int unsigned HWC_IRQ_POL_BIT = 2;
	localparam int unsigned HWC_BUS_W_LO_BIT = 3;
	localparam int unsigned HWC_BUS_W_HI_BIT = 4;
	localparam int unsigned HWC_DREQ_POL_BIT = 5;
	localparam int unsigned HWC_DACK_POL_BIT = 6;
	localparam int unsigned HWC_EOT_POL_BIT = 7;
	localparam int unsigned HWC_DACK_STYLE_BIT = 8;
	localparam int unsigned HWC_OC_ANALOG_BIT = 10;
	localparam int unsigned HWC_CLK_KEEP_BIT = 11;
	localparam int unsigned HWC_PULLDOWN_BIT = 12;
	// writable bits, fixed bits and reset value
	localparam logic [15:0] HWC_WMASK = 16'h1de7;
	localparam logic [15:0] HWC_FIXED = 16'h0008;
	localparam logic [15:0] HWC_RESET = 16'h0028;
	localparam logic [15:0] HWC_ZERO = 16'h0000;
	// edge-style interrupt pulse
	localparam int unsigned HWC_CLK_PERIOD_NS = 5;
	localparam int unsigned HWC_IRQ_PULSE_NS = 50;
	localparam int unsigned HWC_IRQ_PULSE_CYC_I =
		(HWC_IRQ_PULSE_NS + HWC_CLK_PERIOD_NS - 1) / HWC_CLK_PERIOD_NS;
	localparam logic [7:0] HWC_IRQ_PULSE_CYC = 8'(HWC_IRQ_PULSE_CYC_I);
	localparam logic [7:0] HWC_CNT_ZERO = 8'h00;
	localparam logic [7:0] HWC_CNT_ONE = 8'h01;
endpackage

// >>> rtl/hwc_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module hwc_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// reset value is zero; the first edges after release may show a stale level
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule // hwc_sync
`default_nettype wire

// >>> rtl/hwc_top.sv
// host hardware configuration register and the pin behaviour it steers
//
// Contract
// - The register is read with command code 20h and written with code a0h, other codes leave it alone.
// - Bit 0 is the master enable of the host interrupt pin, which asserts only with this bit and an enabled event.
// - Bits 4 and 3 always hold 0 and 1, the 16-bit bus code, whatever is written.
// - Bit 12 selects internal pull-downs when 1 and external resistors when 0, the reset value.
// - Bit 11 at 0 lets the clock stop in suspend, at 1 keeps it running.
// - Bit 10 takes overcurrent from the digital input when 0 and from the analog detector when 1.
// - Bit 8 at 0, the reset value, lets the acknowledge input qualify the read and write strobes; 1 is reserved.
// - Bit 7 sets end-of-transfer polarity and bit 6 acknowledge polarity, both active low at 0.
// - Bit 5 sets DMA request polarity, active high at 1, which is the reset value.
// - Bit 2 sets interrupt pin polarity, active low at 0, which is the reset value.
// - Bit 1 picks level style at 0, the reset value, or edge style at 1 for the interrupt.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module hwc_top import hwc_pkg::*; #(
	parameter int unsigned IRQ_SRC_W = 8
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	// processor command port
	input wire logic [7:0] cmd_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	// interrupt sources and their enables from the same clock domain
	input wire logic [IRQ_SRC_W-1:0] irq_event_in,
	input wire logic [IRQ_SRC_W-1:0] cpu_irq_enable_reg_in,
	output logic host_irq_pin_out,
	// dma handshake
	input wire logic dma_req_in,
	output logic dma_req_pin_out,
	input wire logic dma_ack_pin_in,
	input wire logic dma_rd_n_pin_in,
	input wire logic dma_wr_n_pin_in,
	output logic dma_rd_out,
	output logic dma_wr_out,
	input wire logic eot_pin_in,
	output logic eot_out,
	// port power and suspend
	input wire logic oc_digital_pin_in,
	input wire logic oc_analog_in,
	output logic overcurrent_out,
	input wire logic suspend_in,
	output logic clock_stop_ok_out,
	output logic pulldown_internal_sel_out
);
	generate
		if (IRQ_SRC_W < 1 || IRQ_SRC_W > 16) begin : g_bad_width
			$error("IRQ_SRC_W must lie between 1 and 16");
		end
	endgenerate

	// ---------------- configuration register ----------------
	logic [15:0] cfg_q;
	logic [15:0] cfg_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;

	always_comb begin
		cfg_d = cfg_q;
		rdata_d = HWC_ZERO;
		if (wr_in && cmd_in == HWC_WR_CODE) begin
			cfg_d = (wdata_in & HWC_WMASK) | HWC_FIXED;
		end
		if (rd_in && cmd_in == HWC_RD_CODE) begin
			rdata_d = cfg_q;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_q <= HWC_RESET;
			rdata_q <= HWC_ZERO;
		end else begin
			cfg_q <= cfg_d;
			rdata_q <= rdata_d;
		end
	end

	logic irq_master_en;
	logic irq_trigger_sel;
	logic irq_out_pol;
	logic dma_req_pol;
	logic dma_ack_pol;
	logic end_of_transfer_pol;
	logic dma_ack_style;
	logic overcurrent_analog_sel;
	logic suspend_clock_keep;
	logic pulldown_internal_sel;

	always_comb begin
		irq_master_en = cfg_q[HWC_IRQ_EN_BIT];
		irq_trigger_sel = cfg_q[HWC_IRQ_TRIG_BIT];
		irq_out_pol = cfg_q[HWC_IRQ_POL_BIT];
		dma_req_pol = cfg_q[HWC_DREQ_POL_BIT];
		dma_ack_pol = cfg_q[HWC_DACK_POL_BIT];
		end_of_transfer_pol = cfg_q[HWC_EOT_POL_BIT];
		dma_ack_style = cfg_q[HWC_DACK_STYLE_BIT];
		overcurrent_analog_sel = cfg_q[HWC_OC_ANALOG_BIT];
		suspend_clock_keep = cfg_q[HWC_CLK_KEEP_BIT];
		pulldown_internal_sel = cfg_q[HWC_PULLDOWN_BIT];
	end

	// ---------------- pin synchronisers ----------------
	logic [5:0] pins_async;
	logic [5:0] pins_sync;

	// idle-high pins enter inverted, so the zero reset of the synchroniser
	// reads as idle and no false strobe follows reset
	always_comb begin
		pins_async = {oc_analog_in, oc_digital_pin_in, !eot_pin_in,
			!dma_wr_n_pin_in, !dma_rd_n_pin_in, !dma_ack_pin_in};
	end

	hwc_sync #(
		.WIDTH(6)
	) u_sync (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.async_in(pins_async),
		.sync_out(pins_sync)
	);

	// ---------------- interrupt pin ----------------
	logic irq_cond;
	logic irq_cond_q;
	logic irq_cond_d;
	logic [7:0] pulse_cnt_q;
	logic [7:0] pulse_cnt_d;
	logic irq_active;
	logic irq_pin_q;
	logic irq_pin_d;

	always_comb begin
		irq_cond = irq_master_en && |(irq_event_in & cpu_irq_enable_reg_in);
		irq_cond_d = irq_cond;
		pulse_cnt_d = pulse_cnt_q;
		if (irq_trigger_sel && irq_cond && !irq_cond_q) begin
			pulse_cnt_d = HWC_IRQ_PULSE_CYC;
		end else if (pulse_cnt_q != HWC_CNT_ZERO) begin
			pulse_cnt_d = pulse_cnt_q - HWC_CNT_ONE;
		end
		// a running pulse is cut off if the style changes to level mid-way; the pin then follows irq_cond
		if (irq_trigger_sel) begin
			irq_active = pulse_cnt_d != HWC_CNT_ZERO;
		end else begin
			irq_active = irq_cond;
		end
		irq_pin_d = irq_out_pol ? irq_active : !irq_active;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_cond_q <= 1'b0;
			pulse_cnt_q <= HWC_CNT_ZERO;
			irq_pin_q <= 1'b1;
		end else begin
			irq_cond_q <= irq_cond_d;
			pulse_cnt_q <= pulse_cnt_d;
			irq_pin_q <= irq_pin_d;
		end
	end

	// ---------------- dma handshake ----------------
	logic ack_active;
	logic dreq_pin_d;
	logic dma_rd_d;
	logic dma_wr_d;
	logic eot_d;
	logic dreq_pin_q;
	logic dma_rd_q;
	logic dma_wr_q;
	logic eot_q;

	always_comb begin
		// active-high polarity on the acknowledge is reserved; it is honoured as written
		ack_active = pins_sync[0] != dma_ack_pol;
		dreq_pin_d = dma_req_pol ? dma_req_in : !dma_req_in;
		dma_rd_d = 1'b0;
		dma_wr_d = 1'b0;
		if (!dma_ack_style) begin
			dma_rd_d = ack_active && pins_sync[1];
			dma_wr_d = ack_active && pins_sync[2];
		end
		eot_d = pins_sync[3] != end_of_transfer_pol;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			dreq_pin_q <= 1'b0;
			dma_rd_q <= 1'b0;
			dma_wr_q <= 1'b0;
			eot_q <= 1'b0;
		end else begin
			dreq_pin_q <= dreq_pin_d;
			dma_rd_q <= dma_rd_d;
			dma_wr_q <= dma_wr_d;
			eot_q <= eot_d;
		end
	end

	// ---------------- port power and suspend ----------------
	logic oc_d;
	logic clk_stop_d;
	logic pulldown_d;
	logic oc_q;
	logic clk_stop_q;
	logic pulldown_q;

	always_comb begin
		oc_d = overcurrent_analog_sel ? pins_sync[5] : pins_sync[4];
		clk_stop_d = suspend_in && !suspend_clock_keep;
		pulldown_d = pulldown_internal_sel;
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			oc_q <= 1'b0;
			clk_stop_q <= 1'b0;
			pulldown_q <= 1'b0;
		end else begin
			oc_q <= oc_d;
			clk_stop_q <= clk_stop_d;
			pulldown_q <= pulldown_d;
		end
	end

	assign rdata_out = rdata_q;
	assign host_irq_pin_out = irq_pin_q;
	assign dma_req_pin_out = dreq_pin_q;
	assign dma_rd_out = dma_rd_q;
	assign dma_wr_out = dma_wr_q;
	assign eot_out = eot_q;
	assign overcurrent_out = oc_q;
	assign clock_stop_ok_out = clk_stop_q;
	assign pulldown_internal_sel_out = pulldown_q;
endmodule // hwc_top
`default_nettype wire

// >>> testbench/hwc_top_monitor.sv
// assertion checker for the hardware configuration register block
`timescale 1ns/1ps
`default_nettype none
module hwc_top_monitor import hwc_pkg::*; #(
	parameter int unsigned IRQ_SRC_W = 8
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [7:0] cmd_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [15:0] rdata_out,
	input wire logic [IRQ_SRC_W-1:0] irq_event_in,
	input wire logic [IRQ_SRC_W-1:0] cpu_irq_enable_reg_in,
	input wire logic host_irq_pin_out,
	input wire logic dma_req_in,
	input wire logic dma_req_pin_out,
	input wire logic dma_ack_pin_in,
	input wire logic dma_rd_n_pin_in,
	input wire logic dma_rd_out,
	input wire logic suspend_in,
	input wire logic clock_stop_ok_out,
	input wire logic pulldown_internal_sel_out
);
	logic [15:0] cfg_q;
	logic [1:0] up_q;
	logic go, rd_hit, wr_hit;
	assign go = cfg_q[0] && (|(irq_event_in & cpu_irq_enable_reg_in));
	assign rd_hit = rd_in && cmd_in == HWC_RD_CODE;
	assign wr_hit = wr_in && cmd_in == HWC_WR_CODE;
	// shadow copy, so outputs are judged without seeing the body
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_q <= HWC_RESET;
			up_q <= 2'h0;
		end else begin
			if (wr_hit) cfg_q <= (wdata_in & HWC_WMASK) | HWC_FIXED;
			// pin checks wait until the synchronisers hold post-reset values
			if (up_q != 2'h3) up_q <= up_q + 2'h1;
		end
	end
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	rd_data_a: assert property (rd_hit |=> rdata_out == cfg_q)
		else $error("read data wrong");
	rd_idle_a: assert property (!rd_hit |=> rdata_out == HWC_ZERO)
		else $error("read data outside a read");
	pulldown_a: assert property (
		wr_hit ##1 !wr_hit |=> pulldown_internal_sel_out == $past(wdata_in[12], 2))
		else $error("pull-down select wrong");
	clk_stop_a: assert property (
		clock_stop_ok_out == ($past(suspend_in) && !$past(cfg_q[11])))
		else $error("clock stop permission wrong");
	dreq_a: assert property (
		dma_req_pin_out == ($past(dma_req_in) == $past(cfg_q[5])))
		else $error("dma request polarity wrong");
	dma_rd_a: assert property (up_q == 2'h3 |-> dma_rd_out ==
		($past(dma_ack_pin_in, 3) == $past(cfg_q[6]) && !$past(dma_rd_n_pin_in, 3)
		&& !$past(cfg_q[8]))) else $error("dma read strobe wrong");
	irq_lvl_a: assert property (!cfg_q[1] && cfg_q == $past(cfg_q, 11) |->
		host_irq_pin_out == ($past(go) == cfg_q[2])) else $error("level interrupt wrong");
	irq_pulse_a: assert property (cfg_q[1] && $rose(go) |=>
		(host_irq_pin_out == cfg_q[2]) [*8] ##1 (host_irq_pin_out == cfg_q[2]) [*2]
		##1 host_irq_pin_out != cfg_q[2]) else $error("interrupt pulse wrong");
endmodule // hwc_top_monitor
bind hwc_top hwc_top_monitor #(.IRQ_SRC_W(IRQ_SRC_W)) u_monitor (
	.mclk_in(mclk_in),
	.rst_in(rst_in),
	.cmd_in(cmd_in),
	.wdata_in(wdata_in),
	.wr_in(wr_in),
	.rd_in(rd_in),
	.rdata_out(rdata_out),
	.irq_event_in(irq_event_in),
	.cpu_irq_enable_reg_in(cpu_irq_enable_reg_in),
	.host_irq_pin_out(host_irq_pin_out),
	.dma_req_in(dma_req_in),
	.dma_req_pin_out(dma_req_pin_out),
	.dma_ack_pin_in(dma_ack_pin_in),
	.dma_rd_n_pin_in(dma_rd_n_pin_in),
	.dma_rd_out(dma_rd_out),
	.suspend_in(suspend_in),
	.clock_stop_ok_out(clock_stop_ok_out),
	.pulldown_internal_sel_out(pulldown_internal_sel_out)
);
`default_nettype wire

// >>> testbench/hwc_cpu_model.sv
// processor model driving the command port of the configuration register
`timescale 1ns/1ps
`default_nettype none
module hwc_cpu_model (
	input wire logic mclk_in,
	input wire logic [15:0] rdata_in,
	output var logic [7:0] cmd_out,
	output var logic [15:0] wdata_out,
	output var logic wr_out,
	output var logic rd_out
);
	initial begin
		cmd_out = 8'h00;
		wdata_out = 16'h0000;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	task automatic wr(input logic [7:0] c, input logic [15:0] v);
		@(posedge mclk_in);
		cmd_out <= c;
		wdata_out <= v & 16'hfeff; // bit 8 stays 0, its other value is reserved
		wr_out <= 1'b1;
		@(posedge mclk_in);
		wr_out <= 1'b0;
		// released lines flip, so a stale value never passes for a live one
		cmd_out <= ~c;
		wdata_out <= ~v;
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] v);
		@(posedge mclk_in);
		cmd_out <= c;
		rd_out <= 1'b1;
		@(posedge mclk_in);
		rd_out <= 1'b0;
		cmd_out <= ~c;
		#1;
		v = rdata_in;
	endtask
endmodule // hwc_cpu_model
`default_nettype wire

// >>> testbench/test_hwc_top.sv
// self-checking bench for the host hardware configuration register
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module test_hwc_top import hwc_pkg::*; ();
	logic mclk_in = 1'b0, rst_in = 1'b1;
	wire logic [7:0] cmd_in;
	wire logic [15:0] wdata_in;
	wire logic wr_in, rd_in;
	logic [15:0] rdata_out, d;
	logic [7:0] irq_event_in = 8'h00, cpu_irq_enable_reg_in = 8'h00;
	logic dma_req_in = 1'b0, dma_ack_pin_in = 1'b1, dma_rd_n_pin_in = 1'b1;
	logic dma_wr_n_pin_in = 1'b1, eot_pin_in = 1'b1, suspend_in = 1'b0;
	logic oc_digital_pin_in = 1'b0, oc_analog_in = 1'b0;
	logic host_irq_pin_out, dma_req_pin_out, dma_rd_out, dma_wr_out, eot_out;
	logic overcurrent_out, clock_stop_ok_out, pulldown_internal_sel_out;
	int n_errors = 0, tests_run = 0;
	always #2.5 mclk_in = ~mclk_in;
	hwc_top DUT (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.cmd_in(cmd_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.rdata_out(rdata_out),
		.irq_event_in(irq_event_in),
		.cpu_irq_enable_reg_in(cpu_irq_enable_reg_in),
		.host_irq_pin_out(host_irq_pin_out),
		.dma_req_in(dma_req_in),
		.dma_req_pin_out(dma_req_pin_out),
		.dma_ack_pin_in(dma_ack_pin_in),
		.dma_rd_n_pin_in(dma_rd_n_pin_in),
		.dma_wr_n_pin_in(dma_wr_n_pin_in),
		.dma_rd_out(dma_rd_out),
		.dma_wr_out(dma_wr_out),
		.eot_pin_in(eot_pin_in),
		.eot_out(eot_out),
		.oc_digital_pin_in(oc_digital_pin_in),
		.oc_analog_in(oc_analog_in),
		.overcurrent_out(overcurrent_out),
		.suspend_in(suspend_in),
		.clock_stop_ok_out(clock_stop_ok_out),
		.pulldown_internal_sel_out(pulldown_internal_sel_out)
	);
	hwc_cpu_model cpu (.mclk_in(mclk_in), .rdata_in(rdata_out), .cmd_out(cmd_in),
		.wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge mclk_in);
		rst_in <= 1'b0;
		cpu.rd(HWC_RD_CODE, d);
		`CHK(d, HWC_RESET)
		`CHK(host_irq_pin_out, 1'b1)
		cpu.wr(8'ha1, 16'h1c07);
		cpu.rd(8'h21, d);
		`CHK(d, HWC_ZERO)
		cpu.rd(HWC_RD_CODE, d);
		`CHK(d, HWC_RESET)
		$display("reset and code test done");
		@(posedge mclk_in);
		{suspend_in, dma_req_in, dma_ack_pin_in, dma_rd_n_pin_in, oc_analog_in} <= 5'b11001;
		eot_pin_in <= 1'b0;
		cpu.wr(HWC_WR_CODE, 16'hffff);
		cpu.rd(HWC_RD_CODE, d);
		`CHK(d, 16'h1cef)
		tick(3);
		d = {9'h000, pulldown_internal_sel_out, clock_stop_ok_out, dma_req_pin_out,
			dma_rd_out, dma_wr_out, eot_out, overcurrent_out};
		`CHK(d, 16'h0051)
		@(posedge mclk_in);
		irq_event_in <= 8'h80;
		cpu_irq_enable_reg_in <= 8'h81;
		tick(2);
		`CHK(host_irq_pin_out, 1'b1)
		tick(11);
		`CHK(host_irq_pin_out, 1'b0)
		$display("all ones and edge test done");
		cpu.wr(HWC_WR_CODE, 16'h0005);
		tick(2);
		`CHK(host_irq_pin_out, 1'b1)
		@(posedge mclk_in);
		cpu_irq_enable_reg_in <= 8'h01;
		tick(2);
		`CHK(host_irq_pin_out, 1'b0)
		cpu.wr(HWC_WR_CODE, 16'h0000);
		@(posedge mclk_in);
		cpu_irq_enable_reg_in <= 8'h80;
		dma_wr_n_pin_in <= 1'b0;
		tick(4);
		`CHK(host_irq_pin_out, 1'b1)
		d = {9'h000, pulldown_internal_sel_out, clock_stop_ok_out, dma_req_pin_out,
			dma_rd_out, dma_wr_out, eot_out, overcurrent_out};
		`CHK(d, 16'h002e)
		tick(12);
		$display("level and zero test done");
		print_verdict();
	end
	// the tests need well under a thousand cycles
	initial begin
		#20000;
		n_errors++;
		print_verdict();
	end
endmodule // test_hwc_top
`default_nettype wire
